// file: design/fpcr_regs.vh
`ifndef FPCR_REGS_VH
`define FPCR_REGS_VH
// Register indices (32-bit word map); byte address is four times the index
`define FPCR_IDX_FILTER_TYPE 6'h1E
`define FPCR_IDX_WIDE_BW 6'h1F
`define FPCR_IDX_PIN_DIR 6'h20
`define FPCR_IDX_PIN_LEVEL 6'h21
// Reset values
`define FPCR_RST_FILTER_TYPE 8'h00
`define FPCR_RST_WIDE_BW 8'h00
`define FPCR_RST_PIN_DIR 8'h00
`define FPCR_RST_PIN_LEVEL 8'h00
// Field positions
`define FPCR_FT_CH3_HI 7
`define FPCR_FT_CH3_LO 6
`define FPCR_FT_CH2_HI 5
`define FPCR_FT_CH2_LO 4
`define FPCR_FT_CH1_HI 3
`define FPCR_FT_CH1_LO 2
`define FPCR_FT_CH0_HI 1
`define FPCR_FT_CH0_LO 0
`define FPCR_BW_USED_MASK 8'h0F
// Filter type encodings
`define FPCR_FT_WIDEBAND 2'h0
`define FPCR_FT_SINC6 2'h1
`define FPCR_FT_SINC3 2'h2
`define FPCR_FT_SINC3_NOTCH 2'h3
`endif

// file: design/fpcr_pin_bit.v
`timescale 1ns/1ns
// One general-purpose pin: direction, output latch, synchronised input
module fpcr_pin_bit (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire dir_bit,
  input wire wr_en,
  input wire wr_bit,
  input wire pin_in,
  output wire rd_bit,
  output reg pin_out,
  output wire pin_oe_n
);
  reg sync1_reg;
  reg sync2_reg;
  reg latch_reg;

  // Two-stage synchroniser; pin is asynchronous to the clock
  always @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Output latch only accepts writes while an output
  always @(posedge clk) begin
    if (rst) begin
      latch_reg <= 1'b0;
      pin_out <= 1'b0;
    end else if (ce) begin
      if (wr_en && dir_bit) begin
        latch_reg <= wr_bit;
      end
      pin_out <= (wr_en && dir_bit) ? wr_bit : latch_reg;
    end
  end

  // Enable low while driving; input bits read the synchronised level
  assign pin_oe_n = ~dir_bit;
  assign rd_bit = dir_bit ? latch_reg : sync2_reg;
endmodule // fpcr_pin_bit

// file: design/fpcr_top.v
`timescale 1ns/1ns
`include "fpcr_regs.vh"
module fpcr_top (
  input wire CLOCK,
  input wire SYS_RST,
  input wire CLK_EN,
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  output wire [1:0] FILTER_TYPE_CHAN0,
  output wire [1:0] FILTER_TYPE_CHAN1,
  output wire [1:0] FILTER_TYPE_CHAN2,
  output wire [1:0] FILTER_TYPE_CHAN3,
  output wire WIDE_BANDWIDTH_CHAN0,
  output wire WIDE_BANDWIDTH_CHAN1,
  output wire WIDE_BANDWIDTH_CHAN2,
  output wire WIDE_BANDWIDTH_CHAN3,
  input wire [7:0] GPIN_IN,
  output wire [7:0] GPIN_OUT,
  output wire [7:0] GPIN_OE_N
);
  reg [7:0] filter_type_reg;
  reg [7:0] wide_bw_reg;
  reg [7:0] pin_dir_reg;
  reg ack_reg;
  reg [31:0] rdata_next;
  wire [5:0] word_idx;
  wire req;
  wire wr_fire;
  wire rd_fire;
  wire lane0;
  wire hit_ft;
  wire hit_bw;
  wire hit_dir;
  wire hit_lvl;
  wire [7:0] pin_rd;

  // Word index from byte address; low two bits ignored
  assign word_idx = AVS_ADDRESS[7:2];
  assign req = AVS_READ | AVS_WRITE;
  assign lane0 = AVS_BYTEENABLE[0];
  assign hit_ft = (word_idx == `FPCR_IDX_FILTER_TYPE);
  assign hit_bw = (word_idx == `FPCR_IDX_WIDE_BW);
  assign hit_dir = (word_idx == `FPCR_IDX_PIN_DIR);
  assign hit_lvl = (word_idx == `FPCR_IDX_PIN_LEVEL);

  // One wait state per access: request completes on the ack cycle
  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign wr_fire = AVS_WRITE & ack_reg & CLK_EN;
  assign rd_fire = AVS_READ & ~ack_reg & CLK_EN;

  // Ack toggles so back-to-back requests each get a wait state
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      ack_reg <= 1'b0;
    end else if (CLK_EN) begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Configuration registers, written on lane 0 only
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      filter_type_reg <= `FPCR_RST_FILTER_TYPE;
      wide_bw_reg <= `FPCR_RST_WIDE_BW;
      pin_dir_reg <= `FPCR_RST_PIN_DIR;
    end else if (wr_fire && lane0) begin
      if (hit_ft) begin
        filter_type_reg <= AVS_WRITEDATA[7:0];
      end
      if (hit_bw) begin
        wide_bw_reg <= AVS_WRITEDATA[7:0] & `FPCR_BW_USED_MASK;
      end
      if (hit_dir) begin
        pin_dir_reg <= AVS_WRITEDATA[7:0];
      end
    end
  end

  // Per-pin logic, pin n on bit n
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      fpcr_pin_bit u_pin (
        .clk(CLOCK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .dir_bit(pin_dir_reg[gi]),
        .wr_en(wr_fire & lane0 & hit_lvl),
        .wr_bit(AVS_WRITEDATA[gi]),
        .pin_in(GPIN_IN[gi]),
        .rd_bit(pin_rd[gi]),
        .pin_out(GPIN_OUT[gi]),
        .pin_oe_n(GPIN_OE_N[gi])
      );
    end
  endgenerate

  // Read mux; unmapped words read zero, upper bits zero
  always @* begin
    rdata_next = 32'h00000000;
    if (hit_ft) begin
      rdata_next[7:0] = filter_type_reg;
    end else if (hit_bw) begin
      rdata_next[7:0] = wide_bw_reg;
    end else if (hit_dir) begin
      rdata_next[7:0] = pin_dir_reg;
    end else if (hit_lvl) begin
      rdata_next[7:0] = pin_rd;
    end
  end

  // Read data captured in wait cycle, stands on the ack edge
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      AVS_READDATA <= 32'h00000000;
    end else if (rd_fire) begin
      AVS_READDATA <= rdata_next;
    end
  end

  // Filter selection fields to the channel filters
  assign FILTER_TYPE_CHAN3 = filter_type_reg[`FPCR_FT_CH3_HI:`FPCR_FT_CH3_LO];
  assign FILTER_TYPE_CHAN2 = filter_type_reg[`FPCR_FT_CH2_HI:`FPCR_FT_CH2_LO];
  assign FILTER_TYPE_CHAN1 = filter_type_reg[`FPCR_FT_CH1_HI:`FPCR_FT_CH1_LO];
  assign FILTER_TYPE_CHAN0 = filter_type_reg[`FPCR_FT_CH0_HI:`FPCR_FT_CH0_LO];
  // Bandwidth select: 0 gives 0.10825, 1 gives 0.433 of the data rate
  assign WIDE_BANDWIDTH_CHAN0 = wide_bw_reg[0];
  assign WIDE_BANDWIDTH_CHAN1 = wide_bw_reg[1];
  assign WIDE_BANDWIDTH_CHAN2 = wide_bw_reg[2];
  assign WIDE_BANDWIDTH_CHAN3 = wide_bw_reg[3];
endmodule // fpcr_top

// file: tb/fpcr_pins.sv
`timescale 1ns/1ns
// Far-side logic: drives its own level where the block does not drive
module fpcr_pins (
  input wire [7:0] ext,
  input wire [7:0] oe_n,
  input wire [7:0] dout,
  output wire [7:0] pin
);
  // Wire level selected by the block's output enable alone
  assign pin = (oe_n & ext) | (~oe_n & dout);
endmodule // fpcr_pins

// file: tb/fpcr_sva.sv
`timescale 1ns/1ns
module fpcr_sva (
  input wire CLOCK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST,
  input wire WIDE_BANDWIDTH_CHAN0, WIDE_BANDWIDTH_CHAN1, WIDE_BANDWIDTH_CHAN2, WIDE_BANDWIDTH_CHAN3,
  input wire [1:0] FILTER_TYPE_CHAN0, FILTER_TYPE_CHAN1, FILTER_TYPE_CHAN2, FILTER_TYPE_CHAN3,
  input wire [7:0] AVS_ADDRESS, GPIN_IN, GPIN_OUT, GPIN_OE_N,
  input wire [3:0] AVS_BYTEENABLE,
  input wire [31:0] AVS_WRITEDATA, AVS_READDATA
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire [7:0] ft = {FILTER_TYPE_CHAN3, FILTER_TYPE_CHAN2, FILTER_TYPE_CHAN1, FILTER_TYPE_CHAN0};
  wire [3:0] wb = {WIDE_BANDWIDTH_CHAN3, WIDE_BANDWIDTH_CHAN2, WIDE_BANDWIDTH_CHAN1, WIDE_BANDWIDTH_CHAN0};
  // Completed transfers, the edge the master samples
  sequence wr_done(a); AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == a && AVS_BYTEENABLE[0]; endsequence
  sequence rd_done(a); AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == a; endsequence
  // Synchroniser needs a steady pin before the read means anything
  sequence in_steady; $stable(GPIN_IN) [*4]; endsequence
  wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("slow answer");
  ftype_sel_a: assert property (wr_done(8'h78) |=> ft == $past(AVS_WRITEDATA[7:0])) else $error("type");
  bw_sel_a: assert property (wr_done(8'h7C) |=> wb == $past(AVS_WRITEDATA[3:0])) else $error("bw");
  dir_ctl_a: assert property (wr_done(8'h80) |=> GPIN_OE_N == ~$past(AVS_WRITEDATA[7:0])) else $error("dir");
  drive_a: assert property (wr_done(8'h84) |=> ((GPIN_OUT ^ $past(AVS_WRITEDATA[7:0])) & ~GPIN_OE_N) == 8'h00)
    else $error("drive");
  out_hold_a: assert property (!(AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h84) |=> $stable(GPIN_OUT))
    else $error("out moved");
  in_read_a: assert property (in_steady ##0 rd_done(8'h84) |-> ((AVS_READDATA[7:0] ^ GPIN_IN) & GPIN_OE_N) == 8'h00)
    else $error("pin level");
  reset_val_a: assert property ($fell(SYS_RST) |-> GPIN_OE_N == 8'hFF && GPIN_OUT == 8'h00 && ft == 8'h00 && wb == 4'h0)
    else $error("reset");
endmodule // fpcr_sva
bind fpcr_top fpcr_sva chk (.*);

// file: tb/fpcr_tb_top.sv
`timescale 1ns/1ns
module fpcr_tb_top;
  reg CLOCK = 1'b0, SYS_RST = 1'b1, CLK_EN = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  reg [7:0] AVS_ADDRESS = 8'h00, ext = 8'h5A;
  reg [31:0] AVS_WRITEDATA = 32'h0;
  reg [3:0] AVS_BYTEENABLE = 4'hF;
  wire [31:0] AVS_READDATA;
  wire AVS_WAITREQUEST, WIDE_BANDWIDTH_CHAN0, WIDE_BANDWIDTH_CHAN1, WIDE_BANDWIDTH_CHAN2, WIDE_BANDWIDTH_CHAN3;
  wire [1:0] FILTER_TYPE_CHAN0, FILTER_TYPE_CHAN1, FILTER_TYPE_CHAN2, FILTER_TYPE_CHAN3;
  wire [7:0] GPIN_IN, GPIN_OUT, GPIN_OE_N;
  integer err_total = 0, cmp_count = 0, cyc = 0, i;
  reg [31:0] q;
  fpcr_top uut (.*);
  fpcr_pins far (.ext(ext), .oe_n(GPIN_OE_N), .dout(GPIN_OUT), .pin(GPIN_IN));
  always #20 CLOCK = ~CLOCK;
  task end_sim; begin
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  // Whole run is about a hundred cycles; a hang ends here
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin err_total = err_total + 1; end_sim; end
  end
  task chk(input [31:0] got, input [31:0] exp); begin
    cmp_count = cmp_count + 1;
    if (got !== exp) begin err_total = err_total + 1; $display("mismatch %0t got %h exp %h", $time, got, exp); end
  end endtask
  // Holds the request until waitrequest is seen low at an edge
  task xfer(input w, input [7:0] a, input [7:0] d, input [3:0] be); begin
    AVS_ADDRESS <= a; AVS_WRITEDATA <= {24'h000000, d}; AVS_BYTEENABLE <= be; AVS_WRITE <= w; AVS_READ <= !w;
    @(posedge CLOCK);
    while (AVS_WAITREQUEST) @(posedge CLOCK);
    q = AVS_READDATA; AVS_WRITE <= 1'b0; AVS_READ <= 1'b0;
    @(posedge CLOCK);
  end endtask
  task wr(input [7:0] a, input [7:0] d); xfer(1'b1, a, d, 4'hF); endtask
  task rd(input [7:0] a, input [31:0] exp); begin xfer(1'b0, a, 8'h00, 4'hF); chk(q, exp); end endtask
  // Extra edges let the pin synchroniser fill before any read
  task rst; begin SYS_RST <= 1'b1; repeat (8) @(posedge CLOCK); SYS_RST <= 1'b0; repeat (4) @(posedge CLOCK); end endtask
  wire [7:0] ft = {FILTER_TYPE_CHAN3, FILTER_TYPE_CHAN2, FILTER_TYPE_CHAN1, FILTER_TYPE_CHAN0};
  wire [3:0] wb = {WIDE_BANDWIDTH_CHAN3, WIDE_BANDWIDTH_CHAN2, WIDE_BANDWIDTH_CHAN1, WIDE_BANDWIDTH_CHAN0};
  initial begin
    rst;
    rd(8'h78, 32'h0);
    rd(8'h7C, 32'h0);
    rd(8'h80, 32'h0);
    rd(8'h84, 32'h5A);
    chk({24'h0, GPIN_OUT}, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h78, i * 8'h55);
      chk({30'h0, FILTER_TYPE_CHAN2}, i);
    end
    wr(8'h78, 8'h1B);
    chk({24'h0, ft}, 32'h1B);
    xfer(1'b1, 8'h78, 8'h00, 4'hE);
    rd(8'h78, 32'h1B);
    wr(8'h7C, 8'hFF);
    rd(8'h7C, 32'h0F);
    wr(8'h7C, 8'h05);
    chk({28'h0, wb}, 32'h5);
    wr(8'h88, 8'hFF);
    rd(8'h88, 32'h0);
    wr(8'h84, 8'hFF);
    chk({24'h0, GPIN_OUT}, 32'h0);
    rd(8'h84, 32'h5A);
    wr(8'h80, 8'h0F);
    chk({24'h0, GPIN_OE_N}, 32'hF0);
    chk({24'h0, GPIN_OUT}, 32'h0);
    wr(8'h84, 8'hC3);
    chk({28'h0, GPIN_OUT[3:0]}, 32'h3);
    rd(8'h84, 32'h53);
    rst;
    rd(8'h80, 32'h0);
    rd(8'h78, 32'h0);
    end_sim;
  end
endmodule // fpcr_tb_top
